// [rtl/ssff_fault_flags.sv]
/*
 Flag and mask registers for battery, backup supply and serial-link faults,
 with a combined interrupt request.
 Assumes a serial-link decoder on mclk presents register accesses as one-cycle
 strobes and reports its three error kinds as one-cycle pulses; comparator
 levels arrive asynchronously.
*/
// Functional notes
// - Battery falling below 4.7 V latches flag bit 0.
// - Battery overvoltage latches flag bit 1.
// - Battery below 5.7 V latches flag bit 2, independent of bit 0.
// - Serial access to an invalid register sets flag bit 5.
// - Wrong serial clock pulse count sets flag bit 6.
// - Serial checksum mismatch sets flag bit 7.
// - Backup supply undervoltage latches flag bit 11.
// - Flag bit 12 shows live backup switch state; writes ignored.
// - Latched flags clear only on reset or a written one.
// - Mask bits 0..2 gate the battery fault interrupts.
// - Mask bits 5..7 gate the serial-link error interrupts.
// - Mask zero allows, one inhibits; masks reset to zero.
`timescale 1ns/100ps
module ssff_fault_flags
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic battUvLow,
   input wire logic battOv,
   input wire logic battUvHigh,
   input wire logic backupUv,
   input wire logic backupSwitchClosed,
   input wire logic spiReqErr,
   input wire logic spiClkErr,
   input wire logic spiCrcErr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic regSel,
   input wire logic [ssff_pkg::REG_W-1:0] regWdata,
   output logic [ssff_pkg::REG_W-1:0] regRdata_q,
   output logic irqReq_q
);
   import ssff_pkg::*;

   // ----------------------------------------------------------------
   // Synchronisers for the comparator levels
   // ----------------------------------------------------------------
   ssff_sync_if #(.W(N_SYNC)) syncBus (.mclk(mclk), .reset(reset));

   assign syncBus.raw = {backupSwitchClosed, backupUv, battUvHigh, battOv, battUvLow};

   ssff_sync #(.W(N_SYNC)) uSync (.port(syncBus.sync));

   // Unpacked in the same order as the raw vector above
   wire uvLowS;
   wire ovS;
   wire uvHighS;
   wire backupUvS;
   wire switchS;

   assign {switchS, backupUvS, uvHighS, ovS, uvLowS} = syncBus.synced;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic [REG_W-1:0] flag_q;
   logic [REG_W-1:0] flag_d;
   logic [REG_W-1:0] mask_q;
   logic [REG_W-1:0] mask_d;
   logic [REG_W-1:0] rdata_d;
   logic irq_d;

   wire wrFlags = regWrite && (regSel == REG_FLAGS);
   wire wrMasks = regWrite && (regSel == REG_MASKS);
   wire rdFlags = regSel == REG_FLAGS;

   // Comparator flags set on level: a persisting fault re-latches after a clear
   wire [REG_W-1:0] setVec = (REG_W'(uvLowS) << BIT_UV_LOW)
      | (REG_W'(ovS) << BIT_OV)
      | (REG_W'(uvHighS) << BIT_UV_HIGH)
      | (REG_W'(spiReqErr) << BIT_SPI_REQ)
      | (REG_W'(spiClkErr) << BIT_SPI_CLK)
      | (REG_W'(spiCrcErr) << BIT_SPI_CRC)
      | (REG_W'(backupUvS) << BIT_BACKUP_UV);

   wire [REG_W-1:0] clrVec = wrFlags ? (regWdata & FLAG_LATCHED) : '0;

   // Set wins over a clear in the same cycle so no event is lost
   assign flag_d = ((flag_q & ~clrVec) | setVec) & FLAG_LATCHED;

   assign mask_d = wrMasks ? (regWdata & MASK_WRITABLE) : mask_q;

   wire [REG_W-1:0] liveFlags = flag_q | (REG_W'(switchS) << BIT_SWITCH);
   assign rdata_d = !regRead ? regRdata_q : (rdFlags ? liveFlags : mask_q);

   // Backup undervoltage has no mask bit, so it always requests
   wire [REG_W-1:0] pendVec = flag_q & ~mask_q;

   // One cycle behind the flags, traded for a registered interrupt output
   assign irq_d = |pendVec;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         flag_q <= FLAG_RESET;
         mask_q <= MASK_RESET;
         regRdata_q <= '0;
         irqReq_q <= 1'b0;
      end
      else
      begin
         flag_q <= flag_d;
         mask_q <= mask_d;
         regRdata_q <= rdata_d;
         irqReq_q <= irq_d;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   // ----------------------------------------------------------------
   // Flag latching
   // ----------------------------------------------------------------
   a_uvlow_latch: assert property (uvLowS |=> flag_q[BIT_UV_LOW])
      else $error("4.7 V flag not latched");
   a_uvlow_quiet: assert property (!uvLowS && !flag_q[BIT_UV_LOW]
      |=> !flag_q[BIT_UV_LOW])
      else $error("4.7 V flag set with no event");
   a_ov_latch: assert property (ovS |=> flag_q[BIT_OV])
      else $error("overvoltage flag not latched");
   a_ov_quiet: assert property (!ovS && !flag_q[BIT_OV]
      |=> !flag_q[BIT_OV])
      else $error("overvoltage flag set with no event");
   // Either battery threshold may trip alone
   a_uvhigh_latch: assert property (uvHighS |=> flag_q[BIT_UV_HIGH])
      else $error("5.7 V flag not latched");
   a_uvhigh_quiet: assert property (!uvHighS && !flag_q[BIT_UV_HIGH]
      |=> !flag_q[BIT_UV_HIGH])
      else $error("5.7 V flag set with no event");
   a_req_err_set: assert property (spiReqErr |=> flag_q[BIT_SPI_REQ])
      else $error("request error flag not set");
   a_clk_err_set: assert property (spiClkErr |=> flag_q[BIT_SPI_CLK])
      else $error("clock count flag not set");
   a_crc_err_set: assert property (spiCrcErr |=> flag_q[BIT_SPI_CRC])
      else $error("checksum flag not set");
   a_backup_latch: assert property (backupUvS |=> flag_q[BIT_BACKUP_UV])
      else $error("backup undervoltage flag not latched");
   a_switch_live: assert property (regRead && rdFlags |=>
      regRdata_q[BIT_SWITCH] == $past(switchS) && !flag_q[BIT_SWITCH])
      else $error("switch status not live");

   // ----------------------------------------------------------------
   // Clearing, masks and read-back
   // ----------------------------------------------------------------
   a_clear_only_w1: assert property (!wrFlags |=>
      (flag_q & $past(flag_q)) == $past(flag_q))
      else $error("flag cleared without a write of one");
   a_zero_keeps: assert property (wrFlags |=>
      ((flag_q | $past(regWdata)) & $past(flag_q)) == $past(flag_q))
      else $error("write of zero cleared a flag");
   a_clear_one: assert property (wrFlags && regWdata[BIT_SPI_CLK] && !spiClkErr
      |=> !flag_q[BIT_SPI_CLK])
      else $error("write of one left clock count flag set");
   a_mask_write: assert property (wrMasks |=>
      mask_q == ($past(regWdata) & MASK_WRITABLE))
      else $error("mask write not taken");
   a_mask_hold: assert property (!wrMasks |=> $stable(mask_q))
      else $error("mask changed without a write");
   a_read_masks: assert property (regRead && !rdFlags |=>
      regRdata_q == $past(mask_q))
      else $error("mask read wrong");
   a_read_flags: assert property (regRead && rdFlags |=>
      (regRdata_q & FLAG_LATCHED) == $past(flag_q))
      else $error("flag read wrong");

   // ----------------------------------------------------------------
   // Interrupt request
   // ----------------------------------------------------------------
   a_batt_irq: assert property (flag_q[BIT_UV_LOW] && !mask_q[BIT_UV_LOW] |=> irqReq_q)
      else $error("unmasked battery flag gave no interrupt");
   a_ov_irq: assert property (flag_q[BIT_OV] && !mask_q[BIT_OV] |=> irqReq_q)
      else $error("unmasked overvoltage flag gave no interrupt");
   a_uvhigh_irq: assert property (flag_q[BIT_UV_HIGH] && !mask_q[BIT_UV_HIGH]
      |=> irqReq_q)
      else $error("unmasked 5.7 V flag gave no interrupt");
   a_serial_irq: assert property (flag_q[BIT_SPI_CRC] && !mask_q[BIT_SPI_CRC]
      |=> irqReq_q)
      else $error("unmasked checksum flag gave no interrupt");
   a_req_irq: assert property (flag_q[BIT_SPI_REQ] && !mask_q[BIT_SPI_REQ]
      |=> irqReq_q)
      else $error("unmasked request error flag gave no interrupt");
   a_clk_irq: assert property (flag_q[BIT_SPI_CLK] && !mask_q[BIT_SPI_CLK]
      |=> irqReq_q)
      else $error("unmasked clock count flag gave no interrupt");
   // No mask bit guards the backup undervoltage flag
   a_backup_irq: assert property (flag_q[BIT_BACKUP_UV] |=> irqReq_q)
      else $error("backup undervoltage flag gave no interrupt");
   // Bit 11 cannot be masked, so it must be clear for full inhibition
   a_mask_inhibit: assert property ((mask_q == MASK_WRITABLE && !flag_q[BIT_BACKUP_UV]) [*2]
      |-> !irqReq_q)
      else $error("fully masked flags raised interrupt");
   a_irq_drops: assert property (flag_q == '0 [*2] |-> !irqReq_q)
      else $error("interrupt held with no flag");
   a_mask_latch: assert property (mask_q[BIT_SPI_REQ] && spiReqErr |=>
      flag_q[BIT_SPI_REQ] && mask_q[BIT_SPI_REQ])
      else $error("masked flag failed to latch");

   // ----------------------------------------------------------------
   // Coverage
   // ----------------------------------------------------------------
   // Main scenarios the bench is meant to reach
   c_irq_raise: cover property (!irqReq_q ##1 irqReq_q);
   c_clear_flag: cover property (flag_q[BIT_SPI_CLK] ##1 wrFlags ##1 !flag_q[BIT_SPI_CLK]);
   c_set_on_clear: cover property (wrFlags && regWdata[BIT_SPI_CRC] && spiCrcErr);
   c_masked_event: cover property (mask_q[BIT_OV] && ovS);
   c_all_masked: cover property (mask_q == MASK_WRITABLE && flag_q[BIT_SPI_CRC]);

endmodule : ssff_fault_flags

// [rtl/ssff_pkg.sv]
/*
 Constants for the supply and serial-link fault flag block: register selectors,
 field positions, writable and latched bit sets, reset values.
 Assumes nothing of its surroundings.
*/
package ssff_pkg;

   localparam int REG_W = 16;

   // ----------------------------------------------------------------
   // Register selectors
   // ----------------------------------------------------------------
   localparam logic REG_FLAGS = 1'h0;
   localparam logic REG_MASKS = 1'h1;

   // ----------------------------------------------------------------
   // Field positions, shared by flag and mask registers except bits 11 and 12
   // ----------------------------------------------------------------
   localparam int BIT_UV_LOW = 0;
   localparam int BIT_OV = 1;
   localparam int BIT_UV_HIGH = 2;
   localparam int BIT_SPI_REQ = 5;
   localparam int BIT_SPI_CLK = 6;
   localparam int BIT_SPI_CRC = 7;
   localparam int BIT_BACKUP_UV = 11;
   localparam int BIT_SWITCH = 12;

   localparam logic [REG_W-1:0] FLAG_LATCHED = 16'h08E7;
   localparam logic [REG_W-1:0] MASK_WRITABLE = 16'h00E7;
   localparam logic [REG_W-1:0] FLAG_RESET = 16'h0000;
   localparam logic [REG_W-1:0] MASK_RESET = 16'h0000;

   // Number of analogue levels that need synchronising
   localparam int N_SYNC = 5;

endpackage : ssff_pkg

// [rtl/ssff_sync_if.sv]
/*
 Carrier between the fault flag block and its input synchroniser.
 Assumes both ends share mclk and reset.
*/
`timescale 1ns/100ps
interface ssff_sync_if #(parameter int W = 1)
(
   input wire logic mclk,
   input wire logic reset
);
   logic [W-1:0] raw;
   logic [W-1:0] synced;

   modport sync
   (
      input mclk,
      input reset,
      input raw,
      output synced
   );
   modport user
   (
      output raw,
      input synced
   );
endinterface : ssff_sync_if

// [rtl/ssff_sync.sv]
/*
 Two-stage synchroniser for asynchronous comparator levels.
 Assumes the inputs are slow levels, not pulses shorter than a clock.
*/
`timescale 1ns/100ps
module ssff_sync
#(
   parameter int W = 1
)
(
   ssff_sync_if.sync port
);
   logic [W-1:0] meta_q;
   logic [W-1:0] stable_q;

   // First stage is read only by the second stage
   always_ff @(posedge port.mclk or posedge port.reset)
   begin
      if (port.reset)
      begin
         meta_q <= '0;
         stable_q <= '0;
      end
      else
      begin
         meta_q <= port.raw;
         stable_q <= meta_q;
      end
   end

   assign port.synced = stable_q;

endmodule : ssff_sync

// [dv/ssff_host.sv]
/*
 Host model: one-cycle register strobes on mclk.
 Assumes the flag block samples strobes on the rising edge.
*/
`timescale 1ns/100ps
module ssff_host
(
   input wire logic mclk,
   input wire logic [ssff_pkg::REG_W-1:0] regRdata,
   output logic regWrite,
   output logic regRead,
   output logic regSel,
   output logic [ssff_pkg::REG_W-1:0] regWdata
);
   import ssff_pkg::*;
   initial
   begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regSel = 1'b0;
      regWdata = 16'hA5A5;
   end
   task wr(input logic s, input logic [REG_W-1:0] d);
      @(posedge mclk);
      regWrite <= 1'b1;
      regSel <= s;
      regWdata <= d;
      @(posedge mclk);
      regWrite <= 1'b0;
      // Released data lines carry junk, never the last word
      regWdata <= ~d;
   endtask : wr
   task rd(input logic s, output logic [REG_W-1:0] d);
      @(posedge mclk);
      regRead <= 1'b1;
      regSel <= s;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask : rd
endmodule : ssff_host

// [dv/supply_spi_fault_flags_test.sv]
/*
 Self-checking bench for the fault flag block.
 Assumes the host model drives the register strobes.
*/
`timescale 1ns/100ps
module supply_spi_fault_flags_test;
   import ssff_pkg::*;
   localparam int BITS[7] = '{BIT_UV_LOW, BIT_OV, BIT_UV_HIGH, BIT_SPI_REQ,
      BIT_SPI_CLK, BIT_SPI_CRC, BIT_BACKUP_UV};
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic sw = 1'b0;
   logic [REG_W-1:0] ev = '0;
   logic regWrite, regRead, regSel, irq;
   logic [REG_W-1:0] wdata, rdata, m, b, got, e;
   int error_cnt = 0;
   int samples_checked = 0;
   int seed = 20281;
   always #25 mclk = ~mclk;
   ssff_fault_flags dut(.mclk(mclk), .reset(reset), .battUvLow(ev[BIT_UV_LOW]),
      .battOv(ev[BIT_OV]), .battUvHigh(ev[BIT_UV_HIGH]), .backupUv(ev[BIT_BACKUP_UV]),
      .backupSwitchClosed(sw), .spiReqErr(ev[BIT_SPI_REQ]), .spiClkErr(ev[BIT_SPI_CLK]),
      .spiCrcErr(ev[BIT_SPI_CRC]), .regWrite(regWrite), .regRead(regRead),
      .regSel(regSel), .regWdata(wdata), .regRdata_q(rdata), .irqReq_q(irq));
   ssff_host host(.mclk(mclk), .regRdata(rdata), .regWrite(regWrite),
      .regRead(regRead), .regSel(regSel), .regWdata(wdata));
   // ----------------------------------------------------------------
   // Expectations and checks
   // ----------------------------------------------------------------
   function automatic logic [REG_W-1:0] expFlags(logic [REG_W-1:0] f, logic s);
      return (f & FLAG_LATCHED) | ({15'h0000, s} << BIT_SWITCH);
   endfunction : expFlags
   function automatic logic expIrq(logic [REG_W-1:0] f, logic [REG_W-1:0] k);
      return |(f & FLAG_LATCHED & ~(k & MASK_WRITABLE));
   endfunction : expIrq
   task chk16(string n, logic [REG_W-1:0] e, logic [REG_W-1:0] g);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk16
   task chk1(string n, logic e, logic g);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("MISMATCH %s exp %b got %b", n, e, g);
      end
   endtask : chk1
   task test_done;
      if (error_cnt == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      test_done;
   end
   initial
   begin
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      host.rd(REG_FLAGS, got);
      chk16("flags", FLAG_RESET, got);
      host.rd(REG_MASKS, got);
      chk16("masks", MASK_RESET, got);
      for (int k = 0; k < 7; k++)
      begin
         @(posedge mclk);
         m = 16'($random(seed));
         b = 16'h0001 << BITS[k];
         m = m | b;
         sw <= m[BIT_SWITCH];
         host.wr(REG_MASKS, m);
         host.rd(REG_MASKS, got);
         chk16("masks", m & MASK_WRITABLE, got);
         @(posedge mclk);
         ev <= b;
         repeat (4) @(posedge mclk);
         ev <= '0;
         repeat (4) @(posedge mclk);
         // Zeros at the set bit, ones elsewhere incl. the live status bit
         host.wr(REG_FLAGS, ~b);
         host.rd(REG_FLAGS, got);
         e = expFlags(b, sw);
         chk16("flags", e, got);
         chk1("irq", expIrq(b, m), irq);
         host.wr(REG_MASKS, 16'h0000);
         repeat (2) @(posedge mclk);
         #1 chk1("irq", 1'b1, irq);
         host.wr(REG_FLAGS, b);
         repeat (2) @(posedge mclk);
         #1 chk1("irq", 1'b0, irq);
         host.rd(REG_FLAGS, got);
         chk16("flags", expFlags(16'h0000, sw), got);
      end
      // Corner: every mask set while all maskable faults fire at once
      host.wr(REG_MASKS, 16'hFFFF);
      @(posedge mclk);
      ev <= MASK_WRITABLE;
      repeat (4) @(posedge mclk);
      ev <= '0;
      repeat (4) @(posedge mclk);
      #1 chk1("irq", 1'b0, irq);
      host.rd(REG_FLAGS, got);
      chk16("flags", expFlags(MASK_WRITABLE, sw), got);
      // Corner: a checksum error in the clearing cycle keeps its flag
      fork
         host.wr(REG_FLAGS, MASK_WRITABLE);
         begin
            @(posedge mclk);
            ev[BIT_SPI_CRC] <= 1'b1;
            @(posedge mclk);
            ev[BIT_SPI_CRC] <= 1'b0;
         end
      join
      host.rd(REG_FLAGS, got);
      chk16("flags", expFlags(16'h0001 << BIT_SPI_CRC, sw), got);
      host.rd(REG_MASKS, got);
      chk16("masks", MASK_WRITABLE, got);
      host.wr(REG_MASKS, 16'h0000);
      repeat (2) @(posedge mclk);
      #1 chk1("irq", 1'b1, irq);
      // Corner: a reset mid-run clears flags and the outputs; masks stay zero
      @(posedge mclk);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      #1 chk16("rdata", 16'h0000, rdata);
      chk1("irq", 1'b0, irq);
      repeat (3) @(posedge mclk);
      host.rd(REG_FLAGS, got);
      chk16("flags", expFlags(16'h0000, sw), got);
      host.rd(REG_MASKS, got);
      chk16("masks", MASK_RESET, got);
      test_done;
   end
endmodule : supply_spi_fault_flags_test
